// *** logic/bfg_guard.sv ***
/*
 * Boot flash self-program guard: area decode, lock checks, halt and
 * read blocking during page operations, AXI4-Lite register slave.
 * Assumes CPU requests on clk_sys and fuse and erase pins asynchronous.
 */
`timescale 1ns/1ps
`include "bfg_params.svh"
module bfg_guard #(
    parameter int unsigned PROG_CYCLES =
        `BFG_PROG_TIME_US * `BFG_CLK_MHZ,
    parameter int CNT_W = 20
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ce,
    // Fuse and chip erase pins
    input wire logic [1:0] boot_size_fuses,
    input wire logic chip_erase_pin,
    // CPU side
    input wire logic [15:0] pc,
    input wire logic ivec_in_boot,
    input wire bfg_pkg::bfg_store_req_t store_req,
    input wire bfg_pkg::bfg_load_req_t load_req,
    // CPU results
    output logic cpu_halt,
    output logic readable_area_busy_flag,
    output logic irq_suppress,
    output logic store_done,
    output logic store_refused,
    output logic load_grant,
    output logic load_refused,
    // Flash array control
    output logic flash_start,
    output bfg_pkg::bfg_op_t flash_op,
    output logic [15:0] flash_addr,
    // AXI4-Lite write
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ************************************************
    // Area decode
    // ************************************************
    function automatic logic at_or_above(
        input logic [15:0] addr,
        input logic [16:0] base
    );
        at_or_above = {1'b0, addr} >= base;
    endfunction : at_or_above

    // ************************************************
    // Pin synchronisers
    // ************************************************
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
        end else if (ce) begin
            sync1_reg <= {chip_erase_pin, boot_size_fuses};
            sync2_reg <= sync1_reg;
        end
    end

    // ************************************************
    // Core state
    // ************************************************
    bfg_pkg::bfg_state_t state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [3:0] lock_reg, lock_next;
    logic [16:0] boot_start_reg, boot_start_next;
    logic halt_reg, halt_next;
    logic busy_reg, busy_next;
    logic irq_reg, irq_next;
    logic done_reg, done_next;
    logic refd_reg, refd_next;
    logic grant_reg, grant_next;
    logic lrefd_reg, lrefd_next;
    logic start_reg, start_next;
    bfg_pkg::bfg_op_t op_reg, op_next;
    logic [15:0] faddr_reg, faddr_next;

    // Bus write effects
    logic wr_lock;
    logic wr_reen;
    logic [3:0] wr_lock_val;

    // Area relations
    logic pc_boot, tgt_boot, ld_boot, tgt_stall, ld_stall;
    logic [1:0] st_blk, ld_blk, irq_blk;
    logic [1:0] exec_in, tgt_in, ld_in, vec_in, l_hi, l_lo;
    logic [16:0] boot_calc;

    always_comb begin
        boot_calc = `BFG_FLASH_TOP -
            (`BFG_BOOT_MIN_BYTES << (2'h3 - sync2_reg[1:0]));
    end

    assign pc_boot = at_or_above(pc, boot_start_reg);
    assign tgt_boot = at_or_above(store_req.addr, boot_start_reg);
    assign ld_boot = at_or_above(load_req.addr, boot_start_reg);
    assign tgt_stall = at_or_above(store_req.addr,
        {1'b0, `BFG_STALL_START});
    assign ld_stall = at_or_above(load_req.addr,
        {1'b0, `BFG_STALL_START});

    // Index 0 is the application area, index 1 the boot area
    assign exec_in = {pc_boot, ~pc_boot};
    assign tgt_in = {tgt_boot, ~tgt_boot};
    assign ld_in = {ld_boot, ~ld_boot};
    assign vec_in = {ivec_in_boot, ~ivec_in_boot};
    assign l_hi = {lock_reg[`BFG_LOCK_BOOT_HI], lock_reg[`BFG_LOCK_APP_HI]};
    assign l_lo = {lock_reg[`BFG_LOCK_BOOT_LO], lock_reg[`BFG_LOCK_APP_LO]};

    // ************************************************
    // Lock evaluation per area
    // ************************************************
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_area
            logic ld_unused;
            logic st_unused;
            bfg_lock_eval u_store (
                .lock_hi(l_hi[g]),
                .lock_lo(l_lo[g]),
                .exec_in(exec_in[g]),
                .tgt_in(tgt_in[g]),
                .vec_in(vec_in[g]),
                .store_blk(st_blk[g]),
                .load_blk(st_unused),
                .irq_blk(irq_blk[g])
            );
            bfg_lock_eval u_load (
                .lock_hi(l_hi[g]),
                .lock_lo(l_lo[g]),
                .exec_in(exec_in[g]),
                .tgt_in(ld_in[g]),
                .vec_in(vec_in[g]),
                .store_blk(ld_unused),
                .load_blk(ld_blk[g]),
                .irq_blk()
            );
        end
    endgenerate

    // ************************************************
    // Core next state
    // ************************************************
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        lock_next = lock_reg;
        halt_next = halt_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        refd_next = 1'b0;
        start_next = 1'b0;
        op_next = op_reg;
        faddr_next = faddr_reg;
        // Clamp keeps the boot area inside the stalling area
        if (boot_calc < {1'b0, `BFG_STALL_START}) begin
            boot_start_next = {1'b0, `BFG_STALL_START};
        end else begin
            boot_start_next = boot_calc;
        end
        if (wr_reen && state_reg == bfg_pkg::ST_IDLE) begin
            busy_next = 1'b0;
        end
        if (wr_lock) begin
            lock_next = lock_reg & wr_lock_val;
        end
        unique case (state_reg)
            bfg_pkg::ST_IDLE: begin
                if (store_req.valid) begin
                    if (!pc_boot) begin
                        refd_next = 1'b1;
                    end else begin
                        unique case (store_req.op)
                            bfg_pkg::OP_LOCK: begin
                                lock_next = lock_next &
                                    store_req.data[3:0];
                                done_next = 1'b1;
                            end
                            bfg_pkg::OP_FILL: begin
                                start_next = 1'b1;
                                op_next = store_req.op;
                                faddr_next = store_req.addr;
                                done_next = 1'b1;
                            end
                            bfg_pkg::OP_ERASE,
                            bfg_pkg::OP_WRITE: begin
                                if (|st_blk) begin
                                    refd_next = 1'b1;
                                end else begin
                                    // Any page, boot area too
                                    start_next = 1'b1;
                                    op_next = store_req.op;
                                    faddr_next = store_req.addr;
                                    state_next = bfg_pkg::ST_RUN;
                                    cnt_next = CNT_W'(PROG_CYCLES - 1);
                                    halt_next = tgt_stall;
                                    busy_next = 1'b1;
                                end
                            end
                        endcase
                    end
                end
            end
            bfg_pkg::ST_RUN: begin
                if (store_req.valid) begin
                    refd_next = 1'b1;
                end
                if (cnt_reg == '0) begin
                    state_next = bfg_pkg::ST_IDLE;
                    halt_next = 1'b0;
                    done_next = 1'b1;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
        endcase
        if (sync2_reg[2]) begin
            lock_next = `BFG_LOCK_RST;
        end
        irq_next = irq_blk[0] | irq_blk[1];
        grant_next = 1'b0;
        lrefd_next = 1'b0;
        if (load_req.valid) begin
            if (halt_reg || halt_next) begin
                lrefd_next = 1'b1;
            end else if ((busy_reg || busy_next) && !ld_stall) begin
                lrefd_next = 1'b1;
            end else if (!load_req.is_fetch && |ld_blk) begin
                lrefd_next = 1'b1;
            end else begin
                grant_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= bfg_pkg::ST_IDLE;
            cnt_reg <= '0;
            lock_reg <= `BFG_LOCK_RST;
            boot_start_reg <= `BFG_FLASH_TOP;
            halt_reg <= 1'b0;
            busy_reg <= 1'b0;
            irq_reg <= 1'b0;
            done_reg <= 1'b0;
            refd_reg <= 1'b0;
            grant_reg <= 1'b0;
            lrefd_reg <= 1'b0;
            start_reg <= 1'b0;
            op_reg <= bfg_pkg::OP_FILL;
            faddr_reg <= 16'h0000;
        end else if (ce) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            lock_reg <= lock_next;
            boot_start_reg <= boot_start_next;
            halt_reg <= halt_next;
            busy_reg <= busy_next;
            irq_reg <= irq_next;
            done_reg <= done_next;
            refd_reg <= refd_next;
            grant_reg <= grant_next;
            lrefd_reg <= lrefd_next;
            start_reg <= start_next;
            op_reg <= op_next;
            faddr_reg <= faddr_next;
        end
    end

    assign cpu_halt = halt_reg;
    assign readable_area_busy_flag = busy_reg;
    assign irq_suppress = irq_reg;
    assign store_done = done_reg;
    assign store_refused = refd_reg;
    assign load_grant = grant_reg;
    assign load_refused = lrefd_reg;
    assign flash_start = start_reg;
    assign flash_op = op_reg;
    assign flash_addr = faddr_reg;

    // ************************************************
    // AXI4-Lite slave
    // ************************************************
    logic aw_have_reg, aw_have_next;
    logic [11:0] aw_addr_reg, aw_addr_next;
    logic w_have_reg, w_have_next;
    logic [7:0] w_data_reg, w_data_next;
    logic w_strb_reg, w_strb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic awrdy_reg, awrdy_next;
    logic wrdy_reg, wrdy_next;
    logic arrdy_reg, arrdy_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic do_wr;

    always_comb begin
        aw_have_next = aw_have_reg;
        aw_addr_next = aw_addr_reg;
        w_have_next = w_have_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        wr_lock = 1'b0;
        wr_reen = 1'b0;
        wr_lock_val = w_data_reg[3:0];
        if (s_axi_awvalid && awrdy_reg) begin
            aw_have_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && wrdy_reg) begin
            w_have_next = 1'b1;
            w_data_next = s_axi_wdata[7:0];
            w_strb_next = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        do_wr = aw_have_reg && w_have_reg && !bvalid_reg;
        if (do_wr) begin
            aw_have_next = 1'b0;
            w_have_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = 2'h0;
            unique case (aw_addr_reg)
                `BFG_OFS_CTRL:
                    wr_reen = w_strb_reg &
                        w_data_reg[`BFG_CTRL_REEN];
                `BFG_OFS_LOCK:
                    wr_lock = w_strb_reg;
                `BFG_OFS_CONF: ;
                default:
                    bresp_next = 2'h2;
            endcase
        end
        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        if (s_axi_arvalid && arrdy_reg) begin
            rvalid_next = 1'b1;
            rresp_next = 2'h0;
            rdata_next = 32'h0000_0000;
            unique case (s_axi_araddr)
                `BFG_OFS_CTRL: begin
                    rdata_next[`BFG_CTRL_BUSY] = busy_reg;
                    rdata_next[`BFG_CTRL_RUN] =
                        state_reg == bfg_pkg::ST_RUN;
                    rdata_next[`BFG_CTRL_HALT] = halt_reg;
                end
                `BFG_OFS_LOCK:
                    rdata_next[3:0] = lock_reg;
                `BFG_OFS_CONF: begin
                    rdata_next[`BFG_CONF_FUSE +: 2] = sync2_reg[1:0];
                    rdata_next[`BFG_CONF_START +: 16] =
                        boot_start_reg[15:0];
                end
                default:
                    rresp_next = 2'h2;
            endcase
        end
        awrdy_next = !aw_have_next && !bvalid_next;
        wrdy_next = !w_have_next && !bvalid_next;
        arrdy_next = !rvalid_next;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            aw_have_reg <= 1'b0;
            aw_addr_reg <= 12'h000;
            w_have_reg <= 1'b0;
            w_data_reg <= 8'h00;
            w_strb_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'h0;
            awrdy_reg <= 1'b0;
            wrdy_reg <= 1'b0;
            arrdy_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= 2'h0;
        end else if (ce) begin
            aw_have_reg <= aw_have_next;
            aw_addr_reg <= aw_addr_next;
            w_have_reg <= w_have_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            awrdy_reg <= awrdy_next;
            wrdy_reg <= wrdy_next;
            arrdy_reg <= arrdy_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    assign s_axi_awready = awrdy_reg;
    assign s_axi_wready = wrdy_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arrdy_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

endmodule : bfg_guard

// *** pkg/bfg_params.svh ***
/*
 * Constants of the boot flash self-program guard: offsets, fields,
 * reset values and timing. Assumes a 40 MHz system clock.
 */
// What this block does
// - Flash stores only start when issued from code inside the boot area
// - Boot-area stores may target any flash address, locks permitting
// - Boot area boundary comes from the boot-size fuses
// - Programming concurrent-read area: CPU runs, reads stalling area only
// - Programming stalling area: CPU halted, no reads served
// - Concurrent-read area never read during programming, any target
// - Boot area always lies inside the stalling area
// - Busy flag reads one while concurrent-read area is blocked
// - Lock bits only program; only chip erase or reset returns them to one
// - General lock modes do not gate store or load operations
// - Lock bit reads 1 unprogrammed; app and boot pairs independent
// - App pair: lo=0 blocks stores, hi=0 blocks boot loads of app
// - App modes 3,4 with boot vectors: no interrupts in app code
// - Boot pair: lo=0 blocks stores, hi=0 blocks app loads of boot
// - Boot modes 3,4 with app vectors: no interrupts in boot code
// - Target address of each erase or write decides halt or read-on
`ifndef BFG_PARAMS_SVH
`define BFG_PARAMS_SVH

`define BFG_CLK_MHZ 40
`define BFG_PROG_TIME_US 4000
`define BFG_STALL_START 16'he000
`define BFG_BOOT_MIN_BYTES 17'h00200
`define BFG_FLASH_TOP 17'h10000

`define BFG_OFS_CTRL 12'h000
`define BFG_OFS_LOCK 12'h004
`define BFG_OFS_CONF 12'h008

`define BFG_CTRL_BUSY 0
`define BFG_CTRL_REEN 1
`define BFG_CTRL_RUN 2
`define BFG_CTRL_HALT 3

`define BFG_LOCK_APP_LO 0
`define BFG_LOCK_APP_HI 1
`define BFG_LOCK_BOOT_LO 2
`define BFG_LOCK_BOOT_HI 3
`define BFG_LOCK_RST 4'hf

`define BFG_CONF_FUSE 0
`define BFG_CONF_START 16

`endif

// *** pkg/bfg_pkg.sv ***
/*
 * Types of the boot flash self-program guard.
 * Assumes the CPU core shares the system clock.
 */
package bfg_pkg;

    typedef enum logic [1:0] {
        OP_FILL = 2'b00,
        OP_ERASE = 2'b01,
        OP_WRITE = 2'b10,
        OP_LOCK = 2'b11
    } bfg_op_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN = 1'b1
    } bfg_state_t;

    typedef struct packed {
        logic valid;
        bfg_op_t op;
        logic [15:0] addr;
        logic [7:0] data;
    } bfg_store_req_t;

    typedef struct packed {
        logic valid;
        logic is_fetch;
        logic [15:0] addr;
    } bfg_load_req_t;

endpackage : bfg_pkg

// *** logic/bfg_lock_eval.sv ***
/*
 * Lock pair decoder for one flash area.
 * Assumes area flags computed by the instantiating guard.
 */
`timescale 1ns/1ps
module bfg_lock_eval (
    // Lock pair, 1 = unprogrammed
    input wire logic lock_hi,
    input wire logic lock_lo,
    // Area relations
    input wire logic exec_in,
    input wire logic tgt_in,
    input wire logic vec_in,
    // Decisions
    output logic store_blk,
    output logic load_blk,
    output logic irq_blk
);
    // Modes 2,3 block stores into this area
    assign store_blk = tgt_in & ~lock_lo;
    // Modes 3,4 block loads from the other area
    assign load_blk = tgt_in & ~exec_in & ~lock_hi;
    assign irq_blk = exec_in & ~vec_in & ~lock_hi;
endmodule : bfg_lock_eval

// *** bench/bfg_guard_assertions.sv ***
/*
 * Checker for the boot flash self-program guard ports.
 * Assumes ce held high and a single clock domain.
 */
`timescale 1ns/1ps
module bfg_guard_assertions #(
    parameter int unsigned PROG_CYCLES = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ce,
    // CPU side
    input wire logic [15:0] pc,
    input wire bfg_pkg::bfg_store_req_t store_req,
    input wire bfg_pkg::bfg_load_req_t load_req,
    // Results
    input wire logic cpu_halt,
    input wire logic readable_area_busy_flag,
    input wire logic store_done,
    input wire logic store_refused,
    input wire logic load_grant,
    input wire logic load_refused,
    input wire logic flash_start,
    input wire logic [15:0] flash_addr,
    input wire logic s_axi_bvalid
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    int unsigned halt_cnt_reg;
    always_ff @(posedge clk_sys or negedge rst_b)
        if (!rst_b) halt_cnt_reg <= 0;
        else halt_cnt_reg <= cpu_halt ? halt_cnt_reg + 1 : 0;
    sequence store_take_s;
        ce && store_req.valid;
    endsequence
    sequence load_take_s;
        ce && load_req.valid;
    endsequence
    app_store_a: assert property (store_take_s ##0 pc < 16'he000
        |=> store_refused && !flash_start) else $error("app store ran");
    start_cause_a: assert property (flash_start
        |-> $past(store_req.valid) && !store_refused) else $error("stray start");
    busy_start_a: assert property (flash_start && !store_done
        |-> readable_area_busy_flag) else $error("busy not set");
    stall_halt_a: assert property (flash_start && flash_addr >= 16'he000
        |-> cpu_halt) else $error("no halt");
    rww_run_a: assert property (flash_start && flash_addr < 16'he000
        |-> !cpu_halt) else $error("halt on rww op");
    halt_len_a: assert property ($fell(cpu_halt)
        |-> store_done && halt_cnt_reg == PROG_CYCLES) else $error("halt len");
    rww_block_a: assert property (load_take_s ##0 readable_area_busy_flag
        && load_req.addr < 16'he000 |=> load_refused && !load_grant)
        else $error("rww read served");
    halt_load_a: assert property (load_take_s ##0 cpu_halt
        |=> load_refused) else $error("read while halted");
    busy_clear_a: assert property ($fell(readable_area_busy_flag)
        |-> ##[0:1] s_axi_bvalid) else $error("busy fell alone");
endmodule : bfg_guard_assertions

bind bfg_guard bfg_guard_assertions #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
    .clk_sys, .rst_b, .ce, .pc, .store_req, .load_req, .cpu_halt,
    .readable_area_busy_flag, .store_done, .store_refused, .load_grant,
    .load_refused, .flash_start, .flash_addr, .s_axi_bvalid);

// *** bench/bfg_cpu_model.sv ***
/*
 * CPU core model running loader code against the guard.
 * Assumes the bench calls its tasks and shares clk_sys.
 */
`timescale 1ns/1ps
module bfg_cpu_model (
    // Clock
    input wire logic clk_sys,
    // Requests
    output logic [15:0] pc,
    output logic ivec_in_boot,
    output bfg_pkg::bfg_store_req_t store_req,
    output bfg_pkg::bfg_load_req_t load_req,
    // Answers
    input wire logic store_done,
    input wire logic store_refused,
    input wire logic flash_start,
    input wire logic load_grant,
    input wire logic load_refused
);
    initial begin
        pc = 16'h0000;
        ivec_in_boot = 1'h1; // Vectors kept in boot area
        store_req = '0;
        load_req = '0;
    end
    task run_at(input logic [15:0] a);
        @(posedge clk_sys);
        pc <= a;
    endtask : run_at
    task store(input bfg_pkg::bfg_op_t op, input logic [15:0] a,
               output logic [1:0] r);
        @(posedge clk_sys);
        store_req <= '{1'h1, op, a, 8'h5a};
        @(posedge clk_sys);
        store_req.valid <= 1'h0;
        @(negedge clk_sys);
        r = {store_refused, flash_start | store_done};
    endtask : store
    // Blocked-area loads only where a refusal is expected
    task load(input logic f, input logic [15:0] a, output logic [1:0] r);
        @(posedge clk_sys);
        load_req <= '{1'h1, f, a};
        @(posedge clk_sys);
        load_req.valid <= 1'h0;
        @(negedge clk_sys);
        r = {load_refused, load_grant};
    endtask : load
    task wait_done;
        do @(negedge clk_sys); while (!store_done);
    endtask : wait_done
endmodule : bfg_cpu_model

// *** bench/bfg_guard_bench.sv ***
/*
 * Self-checking bench for the boot flash self-program guard.
 * Assumes the CPU model and the checker bound to the guard.
 */
`timescale 1ns/1ps
module bfg_guard_bench;
    logic clk_sys = 1'h0;
    logic rst_b = 1'h0;
    logic [1:0] boot_size_fuses = 2'h3;
    logic chip_erase_pin = 1'h0, ce = 1'h1;
    logic [15:0] pc;
    bfg_pkg::bfg_store_req_t store_req;
    bfg_pkg::bfg_load_req_t load_req;
    logic cpu_halt, readable_area_busy_flag, irq_suppress, store_done;
    logic store_refused, load_grant, load_refused, flash_start, ivec_in_boot;
    bfg_pkg::bfg_op_t flash_op;
    logic [15:0] flash_addr;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_rvalid;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    int n_errors = 0, tests_run = 0, cyc = 0;
    initial forever #12.5 clk_sys = ~clk_sys;
    bfg_guard #(.PROG_CYCLES(8)) dut (.clk_sys, .rst_b, .ce,
        .boot_size_fuses, .chip_erase_pin, .pc, .ivec_in_boot, .store_req,
        .load_req, .cpu_halt, .readable_area_busy_flag, .irq_suppress,
        .store_done, .store_refused, .load_grant, .load_refused,
        .flash_start, .flash_op, .flash_addr, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    bfg_cpu_model cpu (.clk_sys, .pc, .ivec_in_boot, .store_req, .load_req,
        .store_done, .store_refused, .flash_start, .load_grant,
        .load_refused);
    task tally_and_finish;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task axw(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_awvalid || s_axi_wvalid);
        while (!s_axi_bvalid) @(posedge clk_sys);
        s_axi_bready <= 1'h0;
    endtask : axw
    task axr(input logic [11:0] a);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge clk_sys); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge clk_sys); while (!s_axi_rvalid);
        rd = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask : axr
    task t_config;
        axr(12'h008);
        chk(rd & 32'hffff0003, 32'hfe000003);
        axr(12'h004);
        chk(rd & 32'hf, 32'hf);
        axr(12'h010);
        chk({30'h0, r}, 32'h2);
        cpu.run_at(16'h0100);
        ce <= 1'h0;
        cpu.store(bfg_pkg::OP_ERASE, 16'h1000, r);
        chk({30'h0, r}, 32'h0);
        ce <= 1'h1;
        cpu.store(bfg_pkg::OP_ERASE, 16'h1000, r);
        chk({30'h0, r}, 32'h2);
    endtask : t_config
    task t_rww;
        cpu.run_at(16'hfe00);
        cpu.store(bfg_pkg::OP_ERASE, 16'h1000, r);
        chk({30'h0, r}, 32'h1);
        chk({31'h0, cpu_halt}, 32'h0);
        chk({31'h0, readable_area_busy_flag}, 32'h1);
        cpu.load(1'h1, 16'h0100, r);
        chk({30'h0, r}, 32'h2);
        cpu.load(1'h1, 16'he100, r);
        chk({30'h0, r}, 32'h1);
        cpu.wait_done();
        cpu.load(1'h1, 16'h0100, r);
        chk({30'h0, r}, 32'h2);
        axw(12'h000, 32'h2);
        axr(12'h000);
        chk(rd & 32'h1, 32'h0);
        cpu.load(1'h1, 16'h0100, r);
        chk({30'h0, r}, 32'h1);
    endtask : t_rww
    task t_stall;
        cpu.store(bfg_pkg::OP_WRITE, 16'hfe40, r);
        chk({30'h0, r}, 32'h1);
        chk({31'h0, cpu_halt}, 32'h1);
        cpu.load(1'h1, 16'he100, r);
        chk({30'h0, r}, 32'h2);
        cpu.wait_done();
        chk({31'h0, cpu_halt}, 32'h0);
        axw(12'h000, 32'h2);
    endtask : t_stall
    task t_lock;
        axw(12'h004, 32'h0);
        cpu.store(bfg_pkg::OP_ERASE, 16'h1000, r);
        chk({30'h0, r}, 32'h2);
        chk({31'h0, readable_area_busy_flag}, 32'h0);
        cpu.store(bfg_pkg::OP_ERASE, 16'hfe40, r);
        chk({30'h0, r}, 32'h2);
        cpu.load(1'h0, 16'h0100, r);
        chk({30'h0, r}, 32'h2);
        axw(12'h004, 32'hf);
        axr(12'h004);
        chk(rd & 32'hf, 32'h0);
        chip_erase_pin <= 1'h1;
        repeat (4) @(posedge clk_sys);
        chip_erase_pin <= 1'h0;
        repeat (4) @(posedge clk_sys);
        axr(12'h004);
        chk(rd & 32'hf, 32'hf);
    endtask : t_lock
    task t_fuse;
        boot_size_fuses <= 2'h0;
        repeat (4) @(posedge clk_sys);
        axr(12'h008);
        chk(rd & 32'hffff0003, 32'hf0000000);
        cpu.run_at(16'heffe);
        cpu.store(bfg_pkg::OP_FILL, 16'h0000, r);
        chk({30'h0, r}, 32'h2);
        cpu.run_at(16'hf000);
        cpu.store(bfg_pkg::OP_FILL, 16'h0000, r);
        chk({30'h0, r}, 32'h1);
    endtask : t_fuse
    always @(posedge clk_sys) begin
        if (++cyc == 4000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'h1;
        repeat (4) @(posedge clk_sys);
        t_config();
        t_rww();
        t_stall();
        t_lock();
        t_fuse();
        tally_and_finish();
    end
endmodule : bfg_guard_bench
